//--- flow_pkg.sv
// Package of constants and carrier types for the per-channel flow-control block.
// Assumes one 200 MHz clock and an asynchronous active-low reset.
package flow_pkg;

	// ----------------------------------------
	// Register indices (no printed offsets)
	// ----------------------------------------
	localparam logic [3:0] ADDR_IER = 4'h1;
	localparam logic [3:0] ADDR_ISR_FCR = 4'h2;
	localparam logic [3:0] ADDR_LCR = 4'h3;
	localparam logic [3:0] ADDR_MCR = 4'h4;
	localparam logic [3:0] ADDR_LSR = 4'h5;
	localparam logic [3:0] ADDR_MSR = 4'h6;
	localparam logic [3:0] ADDR_SCR = 4'h7;
	localparam logic [3:0] ADDR_EFC = 4'h8;
	localparam logic [3:0] ADDR_RES1 = 4'h9;
	localparam logic [3:0] ADDR_RES2 = 4'hA;
	localparam logic [3:0] ADDR_PAU1 = 4'hB;
	localparam logic [3:0] ADDR_PAU2 = 4'hC;
	localparam logic [3:0] ADDR_FEATURE_CONTROL_REG = 4'hD;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_ISR = 8'h01;
	localparam logic [7:0] RST_LSR = 8'h60;
	localparam logic [7:0] RST_SCR = 8'hFF;
	localparam logic [7:0] RST_SUMMARY = 8'hFF;

	// ----------------------------------------
	// Protected enhanced bit masks
	// ----------------------------------------
	localparam logic [7:0] MASK_IER = 8'hF0;
	localparam logic [7:0] MASK_ISR = 8'h30;
	localparam logic [7:0] MASK_FCR = 8'h30;
	localparam logic [7:0] MASK_MCR = 8'hE0;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int EFC_ENH = 4;
	localparam int EFC_SPECIAL = 5;
	localparam int EFC_AUTO_RTS = 6;
	localparam int EFC_AUTO_CTS = 7;
	localparam int MCR_RTS = 1;
	localparam int MCR_DTR = 0;
	localparam int ISR_SPECIAL = 4;
	localparam int IER_SPECIAL = 5;
	localparam int LCR_68_IRQ = 7;

	// ----------------------------------------
	// Timing and sizes
	// ----------------------------------------
	localparam logic [7:0] FIFO_DEPTH = 8'h80;
	localparam logic [5:0] HYST_MAX = 6'h34;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_CHAR1 = 3'b001,
		TX_CHAR2 = 3'b010,
		TX_DATA = 3'b011
	} tx_state_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} char_t;

	typedef struct packed {
		logic [3:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} bus_req_t;

endpackage : flow_pkg

//--- remote_port_model.sv
// Far-side serial port model: takes characters from the serializer handshake.
// Assumes the flow block drives ser_valid_i/ser_data_i on clk_sys_i.
`timescale 1ns/1ps
module remote_port_model
	import flow_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Stall control and serial handshake
	input wire logic stall_i,
	input wire logic ser_valid_i,
	input wire logic [7:0] ser_data_i,
	output logic ser_ready_o
);
	logic [1:0] cnt;
	logic [7:0] got[$];

	// Ready one cycle in four while stalling, so held characters must wait
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 2'h0;
			ser_ready_o <= 1'b0;
		end else begin
			cnt <= cnt + 2'h1;
			ser_ready_o <= !stall_i || (cnt == 2'h3);
			if (ser_valid_i && ser_ready_o) begin
				got.push_back(ser_data_i);
			end
		end
	end
endmodule : remote_port_model

//--- test_uart_flow_ctrl.sv
// Self-checking bench for uart_flow_ctrl with a queue-based reference.
// Assumes flow_pkg, uart_flow_ctrl and remote_port_model are compiled first.
`timescale 1ns/1ps
module test_uart_flow_ctrl;
	import flow_pkg::*;
	logic clk_sys_i, rst_n_i, cs_n, wr, rd, sel_n, rx_valid, fifo_ready, tx_valid, cts_n, stall, ser_ready;
	logic [3:0] addr, modem_n, txr_n, rxr_n;
	logic [7:0] wdata, rx_char, rx_fill, rx_trig, tx_data, rdata, fifo_data, ser_data, r, b, d;
	logic oe_n, rx_ready, fifo_valid, tx_ready, ser_valid, rts_n, dtr_n, trdy_n, rrdy_n, ir_o, irq_n, p_irq, s_irq;
	int fail_count, samples_checked, n;
	logic [7:0] got_fifo[$];
	int exp_fifo[$], exp_ser[$];
	logic [3:0] ra[12] = '{ADDR_IER, ADDR_ISR_FCR, ADDR_LCR, ADDR_MCR, ADDR_LSR, ADDR_SCR, ADDR_EFC,
		ADDR_RES1, ADDR_RES2, ADDR_PAU1, ADDR_PAU2, ADDR_FEATURE_CONTROL_REG};
	int rv[12] = '{0, 'h01, 0, 0, 'h60, 'hFF, 0, 0, 0, 0, 0, 0};

	uart_flow_ctrl dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .addr_i(addr), .wr_i(wr),
		.rd_i(rd), .wdata_i(wdata), .summary_select_n_i(sel_n), .rdata_o(rdata), .data_oe_n_o(oe_n),
		.rx_valid_i(rx_valid), .rx_char_i(rx_char), .rx_ready_o(rx_ready), .rx_fill_i(rx_fill),
		.rx_trigger_i(rx_trig), .fifo_valid_o(fifo_valid), .fifo_data_o(fifo_data), .fifo_ready_i(fifo_ready),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready), .ser_valid_o(ser_valid),
		.ser_data_o(ser_data), .ser_ready_i(ser_ready), .cts_n_i(cts_n), .modem_n_i(modem_n),
		.chan_transmit_ready_n_n_i(txr_n), .chan_receive_ready_n_n_i(rxr_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
		.transmit_ready_n_o(trdy_n), .receive_ready_n_o(rrdy_n), .infrared_tx_out_o(ir_o), .irq_n_o(irq_n),
		.pause_irq_o(p_irq), .special_irq_o(s_irq));
	remote_port_model sink (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .stall_i(stall), .ser_valid_i(ser_valid),
		.ser_data_i(ser_data), .ser_ready_o(ser_ready));

	// ----------------------------------------
	// Clock, monitors, watchdog
	// ----------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		if (fifo_valid && fifo_ready) got_fifo.push_back(fifo_data);
		if (tx_ready) tx_valid <= 1'b0;
	end
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		fail_count++;
		test_done();
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [7:0] g, input logic [7:0] e, input string s);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
			fail_count++;
		end
	endtask : chk
	task bw(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys_i) {cs_n, wr, addr, wdata} <= {1'b0, 1'b1, a, v};
		@(posedge clk_sys_i) {cs_n, wr} <= 2'b10;
	endtask : bw
	task br(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_sys_i) {cs_n, rd, addr} <= {1'b0, 1'b1, a};
		@(posedge clk_sys_i) {cs_n, rd} <= 2'b10;
		#1 v = rdata;
		chk({7'h0, oe_n}, 8'h00, "oe");
	endtask : br
	task rx_send(input logic [7:0] c);
		@(posedge clk_sys_i) {rx_valid, rx_char} <= {1'b1, c};
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (rx_ready !== 1'b1 && n < 50);
		rx_valid <= 1'b0;
	endtask : rx_send
	task wait_ser(input int k);
		n = 0;
		while (sink.got.size() < k && n < 300) begin
			@(posedge clk_sys_i);
			n++;
		end
	endtask : wait_ser
	task cmp_q(input string s);
		repeat (8) @(posedge clk_sys_i);
		chk(8'(got_fifo.size()), 8'(exp_fifo.size()), s);
		while (got_fifo.size() > 0 && exp_fifo.size() > 0) chk(got_fifo.pop_front(), 8'(exp_fifo.pop_front()), s);
		chk(8'(sink.got.size()), 8'(exp_ser.size()), s);
		while (sink.got.size() > 0 && exp_ser.size() > 0) chk(sink.got.pop_front(), 8'(exp_ser.pop_front()), s);
		$display("test %s done", s);
	endtask : cmp_q
	task test_done;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h9A37F8CE));
		{rst_n_i, cs_n, wr, rd, sel_n, rx_valid, fifo_ready, tx_valid, cts_n, stall} = 10'b0100101000;
		{addr, wdata, rx_char, tx_data} = '0;
		{rx_fill, rx_trig} = {8'h08, 8'h10};
		modem_n = 4'($urandom);
		{txr_n, rxr_n} = {4'h0, 4'hF};
		repeat (6) @(posedge clk_sys_i);
		chk({1'b0, rts_n, dtr_n, rrdy_n, trdy_n, ir_o, irq_n, oe_n}, 8'h73, "reset pins");
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			br(ra[i], r);
			chk(r, 8'(rv[i]), "reset regs");
		end
		br(ADDR_MSR, r);
		chk(r, {~modem_n, 4'h0}, "modem status");
		br(4'hF, r);
		chk(r, 8'h00, "unmapped");
		// Enhanced bit lock on interrupt-enable and modem-control
		bw(ADDR_IER, 8'hFF);
		bw(ADDR_MCR, 8'hFF);
		br(ADDR_IER, r);
		chk(r, 8'h0F, "ier locked");
		br(ADDR_MCR, r);
		chk(r, 8'h1F, "mcr locked");
		chk({7'h0, rts_n}, 8'h00, "rts gpio");
		bw(ADDR_EFC, 8'h10);
		bw(ADDR_IER, 8'hFF);
		bw(ADDR_MCR, 8'hFF);
		bw(ADDR_EFC, 8'h00);
		bw(ADDR_IER, 8'h00);
		bw(ADDR_MCR, 8'h00);
		br(ADDR_IER, r);
		chk(r, 8'hF0, "ier latched");
		br(ADDR_MCR, r);
		chk(r, 8'hE0, "mcr latched");
		bw(ADDR_EFC, 8'h10);
		bw(ADDR_IER, 8'h00);
		bw(ADDR_MCR, 8'h00);
		cmp_q("lock");
		// Flow character registers and ready summary
		for (int i = 9; i <= 12; i++) begin
			d = 8'($urandom);
			bw(4'(i), d);
			br(4'(i), r);
			chk(r, d, "char reg");
		end
		b = 8'($urandom) & 8'hF0;
		for (int i = 0; i < 4; i++) bw(4'(9 + i), b + 8'(i));
		@(posedge clk_sys_i) {txr_n, rxr_n} <= 8'($urandom);
		repeat (5) @(posedge clk_sys_i);
		@(posedge clk_sys_i) sel_n <= 1'b0;
		@(posedge clk_sys_i) sel_n <= 1'b1;
		#1 chk(rdata, {rxr_n, ~txr_n}, "summary");
		cmp_q("summary");
		// Transmit pause/resume for transmit selections 10, 01 and 11, serializer stalling
		stall <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			d = (i == 0) ? 8'h18 : (i == 1) ? 8'h14 : 8'h1C;
			bw(ADDR_EFC, 8'h10);
			bw(ADDR_EFC, d);
			rx_fill <= 8'h20;
			if (d[3]) exp_ser.push_back(b + 8'h2);
			if (d[2]) exp_ser.push_back(b + 8'h3);
			wait_ser(exp_ser.size());
			rx_fill <= 8'h08;
			if (d[3]) exp_ser.push_back(b);
			if (d[2]) exp_ser.push_back(b + 8'h1);
			wait_ser(exp_ser.size());
			cmp_q("tx flow");
		end
		stall <= 1'b0;
		// Special character detect, then receive mode 01 pause/resume
		bw(ADDR_EFC, 8'h10);
		bw(ADDR_EFC, 8'h30);
		bw(ADDR_IER, 8'h20);
		rx_send(b + 8'h3);
		exp_fifo.push_back(b + 8'h3);
		rx_send(~(b + 8'h3));
		exp_fifo.push_back(~(b + 8'h3));
		br(ADDR_ISR_FCR, r);
		chk(r & 8'h10, 8'h10, "special flag");
		cmp_q("special");
		bw(ADDR_EFC, 8'h31);
		rx_send(b + 8'h3);
		repeat (6) @(posedge clk_sys_i);
		chk(8'(got_fifo.size()), 8'h00, "pause not stored");
		chk({6'h0, p_irq, s_irq}, 8'h03, "pause irqs");
		d = 8'($urandom);
		@(posedge clk_sys_i) {tx_valid, tx_data} <= {1'b1, d};
		repeat (20) @(posedge clk_sys_i);
		chk(8'(sink.got.size()), 8'h00, "paused tx");
		rx_send(b + 8'h1);
		exp_fifo.push_back(b + 8'h1);
		wait_ser(1);
		exp_ser.push_back(d);
		cmp_q("rx pause");
		// Auto clear-to-send
		bw(ADDR_EFC, 8'h10);
		bw(ADDR_EFC, 8'h90);
		cts_n <= 1'b1;
		d = 8'($urandom);
		repeat (4) @(posedge clk_sys_i);
		@(posedge clk_sys_i) {tx_valid, tx_data} <= {1'b1, d};
		repeat (20) @(posedge clk_sys_i);
		chk(8'(sink.got.size()), 8'h00, "cts stall");
		cts_n <= 1'b0;
		wait_ser(1);
		exp_ser.push_back(d);
		cmp_q("cts");
		// Auto request-to-send, then receive buffer fill and drain
		bw(ADDR_EFC, 8'h50);
		rx_fill <= 8'h08;
		repeat (6) @(posedge clk_sys_i);
		chk({7'h0, rts_n}, 8'h01, "rts before assert");
		bw(ADDR_MCR, 8'h02);
		repeat (6) @(posedge clk_sys_i);
		chk({7'h0, rts_n}, 8'h00, "rts low");
		rx_fill <= 8'h20;
		repeat (6) @(posedge clk_sys_i);
		chk({7'h0, rts_n}, 8'h01, "rts high");
		rx_fill <= 8'h08;
		repeat (6) @(posedge clk_sys_i);
		chk({7'h0, rts_n}, 8'h00, "rts again");
		fifo_ready <= 1'b0;
		for (int i = 0; i < 3; i++) exp_fifo.push_back(8'($urandom));
		rx_send(8'(exp_fifo[0]));
		rx_send(8'(exp_fifo[1]));
		fork
			rx_send(8'(exp_fifo[2]));
			begin
				repeat (6) @(posedge clk_sys_i);
				#1 chk({7'h0, rx_ready}, 8'h00, "buffer full");
				@(posedge clk_sys_i) fifo_ready <= 1'b1;
			end
		join
		cmp_q("buffer");
		test_done();
	end
endmodule : test_uart_flow_ctrl

//--- uart_flow_ctrl.sv
// Per-channel flow control, enhanced bit locking, ready summary and reset values.
// Assumes the receive shifter, FIFO counter and serializer sit outside, on the same clock.
//
// Functional notes
// - Flow selection resets to zero, no flow.
// - Upper select bits choose transmitted pause/resume pair.
// - Lower select bits choose received comparison characters.
// - Rx 11 with tx 10/01 accepts either character.
// - Rx 11 with tx 11/00 needs consecutive pair.
// - Enhanced bits writable only while enable set.
// - Reset clears all protected enhanced bits.
// - Special detect compares with pause two, flags.
// - Rx mode 01 with special detect drops pause two, raises interrupts.
// - Auto request-to-send follows fill with hysteresis.
// - Auto request-to-send needs software assert first.
// - Auto clear-to-send stalls transmit data, not flow characters, while high.
// - Four read/write flow character registers.
// - Summary shows inverted tx, plain rx ready.
// - Summary driven while summary select low.
// - Register reset values as documented.
// - Modem status high nibble mirrors inverted inputs.
// - Outputs take documented levels at reset.
// - Paired characters go out one after another.
// - Hysteresis from feature and enhanced bits, up to 52.
`timescale 1ns/1ps
module uart_flow_ctrl
	import flow_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Host register port
	input wire logic cs_n_i,
	input wire logic [3:0] addr_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] wdata_i,
	input wire logic summary_select_n_i,
	output logic [7:0] rdata_o,
	output logic data_oe_n_o,
	// Receive character stream
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_char_i,
	output logic rx_ready_o,
	// Receive FIFO side
	input wire logic [7:0] rx_fill_i,
	input wire logic [7:0] rx_trigger_i,
	output logic fifo_valid_o,
	output logic [7:0] fifo_data_o,
	input wire logic fifo_ready_i,
	// Transmit data path
	input wire logic tx_valid_i,
	input wire logic [7:0] tx_data_i,
	output logic tx_ready_o,
	output logic ser_valid_o,
	output logic [7:0] ser_data_o,
	input wire logic ser_ready_i,
	// Modem and ready pins
	input wire logic cts_n_i,
	input wire logic [3:0] modem_n_i,
	input wire logic [3:0] chan_transmit_ready_n_n_i,
	input wire logic [3:0] chan_receive_ready_n_n_i,
	output logic rts_n_o,
	output logic dtr_n_o,
	output logic transmit_ready_n_o,
	output logic receive_ready_n_o,
	output logic infrared_tx_out_o,
	output logic irq_n_o,
	output logic pause_irq_o,
	output logic special_irq_o
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [12:0] sync1, sync2;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1 <= 13'h1FFF;
			sync2 <= 13'h1FFF;
		end else begin
			sync1 <= {cts_n_i, modem_n_i, chan_transmit_ready_n_n_i, chan_receive_ready_n_n_i};
			sync2 <= sync1;
		end
	end
	wire cts_n = sync2[12];
	wire [3:0] modem_n = sync2[11:8];
	wire [3:0] transmit_ready_n_n = sync2[7:4];
	wire [3:0] receive_ready_n_n = sync2[3:0];

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] interrupt_enable_reg, interrupt_source_reg, fifo_control_reg, line_control_reg, modem_control_reg, line_status_reg, scr, efc, feature_control_reg, enhanced_mode_select;
	logic [7:0] resume_char_one, resume_char_two, pause_char_one, pause_char_two;
	logic [7:0] fifo_ready_summary;
	logic [3:0] msr_low;
	logic strap_done;
	logic cts_prev;
	logic [1:0] settle;
	wire bus_wr = !cs_n_i && wr_i;
	wire bus_rd = !cs_n_i && rd_i;
	wire enh = efc[EFC_ENH];
	wire [1:0] tx_sel = efc[3:2];
	wire [1:0] rx_sel = efc[1:0];
	logic special_set, pause_set;

	function automatic logic [7:0] lock_merge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m,
		input logic en);
		lock_merge = en ? nw : ((old & m) | (nw & ~m));
	endfunction : lock_merge

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			interrupt_enable_reg <= RST_ZERO;
			interrupt_source_reg <= RST_ISR;
			fifo_control_reg <= RST_ZERO;
			line_control_reg <= RST_ZERO;
			modem_control_reg <= RST_ZERO;
			line_status_reg <= RST_LSR;
			scr <= RST_SCR;
			efc <= RST_ZERO;
			feature_control_reg <= RST_ZERO;
			enhanced_mode_select <= RST_ZERO;
			resume_char_one <= RST_ZERO;
			resume_char_two <= RST_ZERO;
			pause_char_one <= RST_ZERO;
			pause_char_two <= RST_ZERO;
			msr_low <= 4'h0;
		end else begin
			if (bus_wr) begin
				case (addr_i)
					ADDR_IER: interrupt_enable_reg <= lock_merge(interrupt_enable_reg, wdata_i, MASK_IER, enh);
					ADDR_ISR_FCR: fifo_control_reg <= lock_merge(fifo_control_reg, wdata_i, MASK_FCR, enh);
					ADDR_LCR: line_control_reg <= wdata_i;
					ADDR_MCR: modem_control_reg <= lock_merge(modem_control_reg, wdata_i, MASK_MCR, enh);
					ADDR_SCR: begin
						if (feature_control_reg[6]) enhanced_mode_select <= wdata_i;
						else scr <= wdata_i;
					end
					ADDR_EFC: efc <= wdata_i;
					ADDR_RES1: resume_char_one <= wdata_i;
					ADDR_RES2: resume_char_two <= wdata_i;
					ADDR_PAU1: pause_char_one <= wdata_i;
					ADDR_PAU2: pause_char_two <= wdata_i;
					ADDR_FEATURE_CONTROL_REG: feature_control_reg <= wdata_i;
					default: ;
				endcase
			end
			// Hardware set wins over a read clear
			if (special_set && (enh || interrupt_source_reg[ISR_SPECIAL])) interrupt_source_reg[ISR_SPECIAL] <= 1'b1;
			else if (bus_rd && addr_i == ADDR_ISR_FCR && enh) interrupt_source_reg[ISR_SPECIAL] <= 1'b0;
			if (pause_set && (enh || interrupt_source_reg[5])) interrupt_source_reg[5] <= 1'b1;
			else if (bus_rd && addr_i == ADDR_ISR_FCR && enh) interrupt_source_reg[5] <= 1'b0;
			interrupt_source_reg[0] <= !(interrupt_source_reg[ISR_SPECIAL] | interrupt_source_reg[5]);
			// Delta only once the synchroniser holds real pin levels
			msr_low[0] <= msr_low[0] | (settle == 2'd3 && sync2[12] != cts_prev);
		end
	end

	// Modem status high nibble captured after release
	logic [3:0] msr_high;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			msr_high <= 4'h0;
			strap_done <= 1'b0;
			cts_prev <= 1'b1;
			settle <= 2'd0;
		end else begin
			msr_high <= ~modem_n;
			strap_done <= 1'b1;
			cts_prev <= sync2[12];
			if (settle != 2'd3) settle <= settle + 2'd1;
		end
	end

	// ----------------------------------------
	// Receive character matching
	// ----------------------------------------
	wire m_res1 = rx_char_i == resume_char_one;
	wire m_res2 = rx_char_i == resume_char_two;
	wire m_pau1 = rx_char_i == pause_char_one;
	wire m_pau2 = rx_char_i == pause_char_two;
	wire paired_rx = rx_sel == 2'b11 && (tx_sel == 2'b11 || tx_sel == 2'b00);
	wire either_rx = rx_sel == 2'b11 && !paired_rx;
	logic pend_res, pend_pau;
	logic rx_take;
	wire pause_hit = (rx_sel == 2'b10 && m_pau1) || (rx_sel == 2'b01 && m_pau2) || (either_rx && (m_pau1 || m_pau2))
		|| (paired_rx && pend_pau && m_pau2);
	wire resume_hit = (rx_sel == 2'b10 && m_res1) || (rx_sel == 2'b01 && m_res2)
		|| (either_rx && (m_res1 || m_res2)) || (paired_rx && pend_res && m_res2);
	wire special_hit = efc[EFC_SPECIAL] && m_pau2;
	wire drop_char = special_hit && rx_sel == 2'b01;
	logic remote_paused;
	assign special_set = rx_take && special_hit;
	assign pause_set = rx_take && pause_hit;

	// ----------------------------------------
	// Two-entry buffer toward the FIFO
	// ----------------------------------------
	char_t buf_q [2];
	logic wr_ptr, rd_ptr;
	logic [1:0] buf_cnt;
	wire buf_full = buf_cnt == 2'd2;
	wire buf_empty = buf_cnt == 2'd0;
	wire push = rx_take && !drop_char;
	wire pop = fifo_valid_o && fifo_ready_i;
	wire head_idx = pop ? !rd_ptr : rd_ptr;
	// Head slot written this cycle: take the incoming character directly
	wire head_new = push && (buf_cnt == {1'b0, pop});
	assign rx_take = rx_valid_i && !buf_full;
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			buf_cnt <= 2'd0;
			pend_res <= 1'b0;
			pend_pau <= 1'b0;
			remote_paused <= 1'b0;
		end else begin
			if (push) begin
				buf_q[wr_ptr] <= '{valid: 1'b1, data: rx_char_i};
				wr_ptr <= !wr_ptr;
			end
			if (pop) rd_ptr <= !rd_ptr;
			buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
			if (rx_take) begin
				pend_res <= paired_rx && m_res1;
				pend_pau <= paired_rx && m_pau1;
				if (pause_hit) remote_paused <= 1'b1;
				else if (resume_hit) remote_paused <= 1'b0;
			end
			if (rx_sel == 2'b00) remote_paused <= 1'b0;
		end
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_ready_o <= 1'b0;
			fifo_valid_o <= 1'b0;
			fifo_data_o <= 8'h00;
		end else begin
			rx_ready_o <= buf_cnt + {1'b0, push} - {1'b0, pop} < 2'd2;
			fifo_valid_o <= !(buf_cnt + {1'b0, push} - {1'b0, pop} == 2'd0);
			fifo_data_o <= head_new ? rx_char_i : buf_q[head_idx].data;
		end
	end

	// ----------------------------------------
	// Auto request-to-send with hysteresis
	// ----------------------------------------
	logic [5:0] hyst;
	always_comb begin
		case ({enhanced_mode_select[5:4], feature_control_reg[1:0]})
			4'h0: hyst = 6'd0; 4'h1: hyst = 6'd4; 4'h2: hyst = 6'd6; 4'h3: hyst = 6'd8;
			4'h4: hyst = 6'd8; 4'h5: hyst = 6'd16; 4'h6: hyst = 6'd24; 4'h7: hyst = 6'd32;
			4'h8: hyst = 6'd40; 4'h9: hyst = 6'd44; 4'hA: hyst = 6'd48; 4'hB: hyst = HYST_MAX;
			4'hC: hyst = 6'd12; 4'hD: hyst = 6'd20; 4'hE: hyst = 6'd28; default: hyst = 6'd36;
		endcase
	end
	wire [8:0] upper_lvl = {1'b0, rx_trigger_i} + {3'b000, hyst};
	wire [8:0] lower_lvl = {1'b0, rx_trigger_i} - {3'b000, hyst};
	logic fill_high;
	wire auto_rts = efc[EFC_AUTO_RTS] && modem_control_reg[MCR_RTS];
	wire buffer_high = (hyst == 6'd0) ? ({1'b0, rx_fill_i} >= upper_lvl) : ({1'b0, rx_fill_i} > upper_lvl);
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) fill_high <= 1'b0;
		else if (buffer_high) fill_high <= 1'b1;
		else if ({1'b0, rx_fill_i} < lower_lvl || lower_lvl[8]) fill_high <= 1'b0;
	end

	// ----------------------------------------
	// Transmitter: flow characters and data
	// ----------------------------------------
	tx_state_t state, next_state;
	logic sent_pause;
	wire want_pause = tx_sel != 2'b00 && fill_high != sent_pause && strap_done;
	wire cts_stop = efc[EFC_AUTO_CTS] && cts_n;
	wire data_ok = !cts_stop && !remote_paused && tx_valid_i;
	wire [7:0] c1 = fill_high ? (tx_sel[1] ? pause_char_one : pause_char_two)
		: (tx_sel[1] ? resume_char_one : resume_char_two);
	wire [7:0] c2 = fill_high ? pause_char_two : resume_char_two;
	wire ser_free = !ser_valid_o || ser_ready_i;
	always_comb begin
		next_state = state;
		case (state)
			TX_IDLE: if (ser_free) next_state = want_pause ? TX_CHAR1 : (data_ok ? TX_DATA : TX_IDLE);
			TX_CHAR1: if (ser_ready_i) next_state = (tx_sel == 2'b11) ? TX_CHAR2 : TX_IDLE;
			TX_CHAR2: if (ser_ready_i) next_state = TX_IDLE;
			TX_DATA: if (ser_ready_i) next_state = TX_IDLE;
			default: next_state = TX_IDLE;
		endcase
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= TX_IDLE;
			sent_pause <= 1'b0;
			ser_valid_o <= 1'b0;
			ser_data_o <= 8'h00;
			tx_ready_o <= 1'b0;
		end else begin
			state <= next_state;
			tx_ready_o <= 1'b0;
			if (state == TX_IDLE && next_state == TX_CHAR1) begin
				ser_valid_o <= 1'b1;
				ser_data_o <= c1;
				sent_pause <= fill_high;
			end else if (state == TX_IDLE && next_state == TX_DATA) begin
				ser_valid_o <= 1'b1;
				ser_data_o <= tx_data_i;
				tx_ready_o <= 1'b1;
			end else if (state == TX_CHAR1 && next_state == TX_CHAR2) begin
				ser_data_o <= c2;
			end else if (ser_ready_i) begin
				ser_valid_o <= 1'b0;
			end
			if (tx_sel == 2'b00) sent_pause <= 1'b0;
		end
	end

	// ----------------------------------------
	// Read mux, summary and pins
	// ----------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		case (addr_i)
			ADDR_IER: rd_mux = interrupt_enable_reg;
			ADDR_ISR_FCR: rd_mux = interrupt_source_reg;
			ADDR_LCR: rd_mux = line_control_reg;
			ADDR_MCR: rd_mux = modem_control_reg;
			ADDR_LSR: rd_mux = line_status_reg;
			ADDR_MSR: rd_mux = {msr_high, msr_low};
			ADDR_SCR: rd_mux = scr;
			ADDR_EFC: rd_mux = efc;
			ADDR_RES1: rd_mux = resume_char_one;
			ADDR_RES2: rd_mux = resume_char_two;
			ADDR_PAU1: rd_mux = pause_char_one;
			ADDR_PAU2: rd_mux = pause_char_two;
			ADDR_FEATURE_CONTROL_REG: rd_mux = feature_control_reg;
			default: rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fifo_ready_summary <= RST_SUMMARY;
			rdata_o <= 8'h00;
			data_oe_n_o <= 1'b1;
			rts_n_o <= 1'b1;
			dtr_n_o <= 1'b1;
			transmit_ready_n_o <= 1'b0;
			receive_ready_n_o <= 1'b1;
			infrared_tx_out_o <= 1'b0;
			irq_n_o <= 1'b1;
			pause_irq_o <= 1'b0;
			special_irq_o <= 1'b0;
		end else begin
			fifo_ready_summary <= {receive_ready_n_n, ~transmit_ready_n_n};
			rdata_o <= !summary_select_n_i ? fifo_ready_summary : rd_mux;
			data_oe_n_o <= !(!summary_select_n_i || bus_rd);
			rts_n_o <= auto_rts ? fill_high : !modem_control_reg[MCR_RTS];
			dtr_n_o <= !modem_control_reg[MCR_DTR];
			transmit_ready_n_o <= buf_full;
			receive_ready_n_o <= buf_empty;
			infrared_tx_out_o <= 1'b0;
			pause_irq_o <= interrupt_source_reg[5] && interrupt_enable_reg[IER_SPECIAL];
			special_irq_o <= interrupt_source_reg[ISR_SPECIAL] && interrupt_enable_reg[IER_SPECIAL];
			irq_n_o <= !(line_control_reg[LCR_68_IRQ] && (interrupt_source_reg[5] | interrupt_source_reg[ISR_SPECIAL]) && interrupt_enable_reg[IER_SPECIAL]);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	lock_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(bus_wr && addr_i == ADDR_IER && !enh) |=> (interrupt_enable_reg[7:4] == $past(interrupt_enable_reg[7:4])))
		else $error("locked enhanced bits changed");
	cts_stall_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state == TX_IDLE && cts_stop && !want_pause) |=> state != TX_DATA)
		else $error("data sent while clear-to-send high");
	drop_pause_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(rx_take && drop_char) |=> buf_cnt <= $past(buf_cnt))
		else $error("dropped character was stored");
	special_flag_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(special_set && enh) |=> interrupt_source_reg[ISR_SPECIAL])
		else $error("special flag not set");
	summary_map_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		strap_done |=> fifo_ready_summary == {$past(receive_ready_n_n), ~$past(transmit_ready_n_n)})
		else $error("summary mismatch");
	summary_drive_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!summary_select_n_i |=> (rdata_o == $past(fifo_ready_summary) && !data_oe_n_o))
		else $error("summary not driven");
	pause_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(remote_paused && !(rx_take && resume_hit) && rx_sel != 2'b00) |=> remote_paused)
		else $error("pause released without resume");
	rts_manual_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		!efc[EFC_AUTO_RTS] |=> rts_n_o == !$past(modem_control_reg[MCR_RTS]))
		else $error("manual request-to-send wrong");
	pair_send_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state == TX_CHAR1 && ser_ready_i && tx_sel == 2'b11) |=> state == TX_CHAR2)
		else $error("second flow character skipped");
	pause_send_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) state == TX_CHAR1);
	pair_rx_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) paired_rx && pause_set);
	buf_full_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) buf_full);
	rts_auto_c: cover property (@(posedge clk_sys_i) disable iff (!rst_n_i) auto_rts && rts_n_o);

endmodule : uart_flow_ctrl
